// [verilog/brte_pkg.sv]
/*
  Constants, types and field layout of the boundary run-test engine.
  Assumes a TAP controller outside that reports its state and the
  decoded instruction, and a 44-cell boundary register held here.
*/
package brte_pkg;
  localparam int CELLS = 44;
  localparam int DATA = 36;
  localparam int HALF = 18;
  localparam int BYTE = 9;
  localparam int CTL_LO = 36;
  // Output-enable cells of the boundary register
  localparam int OE_A1 = 43;
  localparam int OE_B1 = 42;
  localparam int OE_A2 = 41;
  localparam int OE_B2 = 40;
  localparam int TCR_W = 3;
  // Low-bit opcodes and full opcodes of the control register
  localparam logic [1:0] LOW_SAMPLE = 2'h0;
  localparam logic [1:0] LOW_PAT = 2'h1;
  localparam logic [1:0] LOW_SIG = 2'h2;
  localparam logic [2:0] TCR_SIG_PAT = 3'h3;
  localparam logic [2:0] TCR_SIG_CNT = 3'h7;
  localparam logic [2:0] TCR_RST = 3'h0;
  // Feedback taps: x^36+x^25+1 and x^18+x^11+1
  localparam int T36_A = 35;
  localparam int T36_B = 24;
  localparam int T18_A = 17;
  localparam int T18_B = 10;
  // Register map of the AXI4-Lite slave
  localparam int AW = 4;
  localparam logic [AW-1:0] ADDR_CTRL = 4'h0;
  localparam logic [AW-1:0] ADDR_STATUS = 4'h4;
  localparam logic [AW-1:0] ADDR_BND_LO = 4'h8;
  localparam logic [AW-1:0] ADDR_BND_HI = 4'hc;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  localparam int CTRL_EN = 0;
  localparam logic CTRL_EN_RST = 1'b1;
  localparam int SYNC_W = 46;

  typedef enum logic [2:0] {
    OP_IDLE, OP_SAMPLE, OP_PATTERN, OP_SIGNATURE, OP_SIG_PAT, OP_SIG_CNT
  } brte_op_t;

  // State and instruction reported by the TAP controller
  typedef struct packed {
    logic run_test;
    logic toggle;
    logic ctrl_scan;
    logic bnd_sel;
    logic run_idle;
    logic capture_dr;
    logic shift_dr;
    logic update_dr;
  } brte_tap_t;
endpackage

// [verilog/brte_sync.sv]
/*
  Two-flop synchroniser for a bus of independent levels.
  Assumes each bit is a slow level relative to CLK_I.
*/
`timescale 1ns/1ps
module brte_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;

  if (W < 1) $error("brte_sync: width must be positive");

  // First stage feeds only the second
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta_q <= '0;
      q_o <= '0;
    end else begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule

// [verilog/brte_lfsr.sv]
/*
  One step of a shift register with XOR feedback and parallel input.
  Zero data on a zero state yields zero, so it serves as generator
  and as signature compressor. Purely combinational.
*/
`timescale 1ns/1ps
module brte_lfsr #(
  parameter int W = 36,
  parameter int TA = 35,
  parameter int TB = 24
) (
  input wire logic [W-1:0] state_i,
  input wire logic [W-1:0] data_i,
  output logic [W-1:0] next_o
);
  if (W < 2 || TA >= W || TB >= W) $error("brte_lfsr: bad taps");

  // Shift toward the top, feedback into bit 0, fold data in
  assign next_o = {state_i[W-2:0], state_i[TA] ^ state_i[TB]} ^ data_i;
endmodule

// [verilog/brte_engine.sv]
/*
  Boundary run-test engine: toggle-outputs, control-register scan and
  the run-test operations on the boundary register, with TDO, pin
  drive and an AXI4-Lite window onto its state.
  Assumes TCK, TDI, the TAP report and the pins are asynchronous to
  CLK_I and slow against it (TCK at most an eighth of CLK_I).
*/
// Register access over AXI4-Lite and the address map were chosen for this implementation.
`timescale 1ns/1ps
module brte_engine
  import brte_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RESET_N_I,
  input wire logic TCK_I,
  input wire logic TDI_I,
  input wire brte_pkg::brte_tap_t TAP_I,
  output logic TDO_O,
  output logic TDO_OE_O,
  input wire logic [brte_pkg::HALF-1:0] A_I,
  output logic [brte_pkg::HALF-1:0] A_O,
  output logic [brte_pkg::HALF-1:0] A_OE_O,
  input wire logic [brte_pkg::HALF-1:0] B_I,
  output logic [brte_pkg::HALF-1:0] B_O,
  output logic [brte_pkg::HALF-1:0] B_OE_O,
  input wire logic [brte_pkg::AW-1:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [brte_pkg::AW-1:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I
);
  import brte_pkg::*;

  logic [SYNC_W-1:0] syn;
  logic tck_q, rise, fall, tck_s, tdi_s;
  brte_tap_t tap_s, tap_q;
  logic [DATA-1:0] pins_s;
  logic [CELLS-1:0] sr_q, sh_q;
  logic [TCR_W-1:0] tcr_q;
  logic byp_q, tdo_q, tdo_oe_q, test_q, en_q;
  brte_op_t op;

  // All link inputs cross through two flops
  brte_sync #(.W(SYNC_W)) u_sync (
    .clk_i(CLK_I),
    .reset_n_i(RESET_N_I),
    .d_i({TCK_I, TDI_I, TAP_I, B_I, A_I}),
    .q_o(syn)
  );

  assign tck_s = syn[SYNC_W-1];
  assign tdi_s = syn[SYNC_W-2];
  assign tap_s = syn[SYNC_W-3:DATA];
  assign pins_s = syn[DATA-1:0];

  // TCK edge detection
  assign rise = tck_s & ~tck_q;
  assign fall = ~tck_s & tck_q;

  // TAP report latched at the falling edge, stable for the next rise
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      tck_q <= 1'b0;
      tap_q <= '0;
    end else begin
      tck_q <= tck_s;
      if (fall)
        tap_q <= tap_s;
    end
  end

  // Drive direction and mode masks from the enable shadows
  logic dir_ok, b_drv, run_ok, tog_ok, bnd_shift, byp_sel, upd_mode;
  logic [DATA-1:0] out_mask;
  assign dir_ok = (sh_q[OE_A1] != sh_q[OE_B1])
    && (sh_q[OE_A2] != sh_q[OE_B2]) && (sh_q[OE_B1] == sh_q[OE_B2]);
  assign b_drv = sh_q[OE_B1];
  assign out_mask = {{BYTE{sh_q[OE_B2]}}, {BYTE{sh_q[OE_B1]}},
    {BYTE{sh_q[OE_A2]}}, {BYTE{sh_q[OE_A1]}}};
  assign run_ok = tap_q.run_test & tap_q.run_idle & dir_ok & en_q;
  assign tog_ok = tap_q.toggle & tap_q.run_idle & en_q;
  assign bnd_shift = tap_q.shift_dr & tap_q.bnd_sel;
  assign byp_sel = ~tap_q.ctrl_scan & ~tap_q.bnd_sel;
  assign upd_mode = tcr_q[1:0] != LOW_SIG;

  // Opcode decode, bit 2 only splits the 18-bit pair
  assign op = !run_ok ? OP_IDLE :
    (tcr_q[1:0] == LOW_SAMPLE) ? OP_SAMPLE :
    (tcr_q[1:0] == LOW_PAT) ? OP_PATTERN :
    (tcr_q[1:0] == LOW_SIG) ? OP_SIGNATURE :
    (tcr_q == TCR_SIG_CNT) ? OP_SIG_CNT : OP_SIG_PAT;

  // Input and output halves follow the data direction
  logic [HALF-1:0] in_v, out_v, pins_in, nin, nout, n18i, n18o;
  logic [DATA-1:0] n36, d36, run_next;
  assign in_v = b_drv ? sr_q[HALF-1:0] : sr_q[DATA-1:HALF];
  assign out_v = b_drv ? sr_q[DATA-1:HALF] : sr_q[HALF-1:0];
  assign pins_in = b_drv ? pins_s[HALF-1:0] : pins_s[DATA-1:HALF];
  assign d36 = (op == OP_SIGNATURE) ? {{HALF{1'b0}}, pins_in} : '0;

  // Full-width register: output half on top, input half below
  brte_lfsr #(.W(DATA), .TA(T36_A), .TB(T36_B)) u_l36 (
    .state_i({out_v, in_v}),
    .data_i(d36),
    .next_o(n36)
  );

  // Half-width signature over the input cells
  brte_lfsr #(.W(HALF), .TA(T18_A), .TB(T18_B)) u_l18i (
    .state_i(in_v),
    .data_i(pins_in),
    .next_o(n18i)
  );

  // Half-width generator over the output cells
  brte_lfsr #(.W(HALF), .TA(T18_A), .TB(T18_B)) u_l18o (
    .state_i(out_v),
    .data_i({HALF{1'b0}}),
    .next_o(n18o)
  );

  // Next value of the data cells per operation
  always_comb begin
    nin = in_v;
    nout = out_v;
    unique case (op)
      OP_IDLE: begin
        nin = in_v;
      end
      OP_SAMPLE: begin
        nin = pins_in;
        nout = ~out_v;
      end
      OP_PATTERN, OP_SIGNATURE: begin
        {nout, nin} = n36;
      end
      OP_SIG_PAT: begin
        nin = n18i;
        nout = n18o;
      end
      OP_SIG_CNT: begin
        nin = n18i;
        nout = out_v + 18'h1;
      end
    endcase
  end
  assign run_next = b_drv ? {nout, nin} : {nin, nout};

  // Shift stages: scan, run-test step or toggle; only scan touches cells 43..36
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I)
      sr_q <= '0;
    else if (rise && bnd_shift)
      sr_q <= {tdi_s, sr_q[CELLS-1:1]};
    else if (rise && run_ok)
      sr_q[DATA-1:0] <= run_next;
    else if (rise && tog_ok)
      sr_q[DATA-1:0] <= sr_q[DATA-1:0] ^ out_mask;
  end

  // Shadow latches: Update-DR loads all cells; in run-test only output cells follow, none in signature mode
  logic fall_upd, fall_load;
  assign fall_load = fall & tap_s.update_dr & tap_s.bnd_sel;
  assign fall_upd = fall & tap_s.run_idle & en_q
    & ((tap_s.run_test & dir_ok & upd_mode) | tap_s.toggle);
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I)
      sh_q <= '0;
    else if (fall_load)
      sh_q <= sr_q;
    else if (fall_upd)
      sh_q[DATA-1:0] <= (sh_q[DATA-1:0] & ~out_mask)
        | (sr_q[DATA-1:0] & out_mask);
  end

  // Bypass bit and control register scan paths
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      byp_q <= 1'b0;
      tcr_q <= TCR_RST;
    end else if (rise) begin
      if (byp_sel && tap_q.capture_dr)
        byp_q <= 1'b0;
      else if (byp_sel && tap_q.shift_dr)
        byp_q <= tdi_s;
      if (tap_q.ctrl_scan && tap_q.shift_dr)
        tcr_q <= {tdi_s, tcr_q[TCR_W-1:1]};
    end
  end

  // TDO and test mode change on the falling edge
  logic tdo_src;
  assign tdo_src = tap_s.bnd_sel ? sr_q[0] :
    tap_s.ctrl_scan ? tcr_q[0] : byp_q;
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      tdo_q <= 1'b0;
      tdo_oe_q <= 1'b0;
      test_q <= 1'b0;
    end else if (fall) begin
      tdo_q <= tdo_src;
      tdo_oe_q <= tap_s.shift_dr;
      test_q <= tap_s.run_test | tap_s.toggle;
    end
  end

  // Pins driven from the shadows while in test mode
  assign TDO_O = tdo_q;
  assign TDO_OE_O = tdo_oe_q;
  assign A_O = sh_q[HALF-1:0];
  assign B_O = sh_q[DATA-1:HALF];
  assign A_OE_O = out_mask[HALF-1:0] & {HALF{test_q}};
  assign B_OE_O = out_mask[DATA-1:HALF] & {HALF{test_q}};

  // AXI4-Lite write channel: address and data taken in either order
  logic [AW-1:0] aw_q;
  logic awv_q, wv_q, bv_q, rv_q;
  logic [31:0] wd_q;
  logic [3:0] ws_q;
  logic [1:0] bresp_q;
  logic wr_go, aw_hit, ar_hit;
  assign S_AXI_AWREADY_O = ~awv_q & ~bv_q;
  assign S_AXI_WREADY_O = ~wv_q & ~bv_q;
  assign wr_go = awv_q & wv_q & ~bv_q;
  assign aw_hit = aw_q == ADDR_CTRL || aw_q == ADDR_STATUS
    || aw_q == ADDR_BND_LO || aw_q == ADDR_BND_HI;
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      awv_q <= 1'b0;
      wv_q <= 1'b0;
      bv_q <= 1'b0;
      aw_q <= '0;
      wd_q <= '0;
      ws_q <= '0;
      bresp_q <= RESP_OK;
      en_q <= CTRL_EN_RST;
    end else begin
      if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
        awv_q <= 1'b1;
        aw_q <= S_AXI_AWADDR_I;
      end
      if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
        wv_q <= 1'b1;
        wd_q <= S_AXI_WDATA_I;
        ws_q <= S_AXI_WSTRB_I;
      end
      if (wr_go) begin
        awv_q <= 1'b0;
        wv_q <= 1'b0;
        bv_q <= 1'b1;
        bresp_q <= aw_hit ? RESP_OK : RESP_ERR;
        if (aw_q == ADDR_CTRL && ws_q[0])
          en_q <= wd_q[CTRL_EN];
      end else if (bv_q && S_AXI_BREADY_I)
        bv_q <= 1'b0;
    end
  end
  assign S_AXI_BVALID_O = bv_q;
  assign S_AXI_BRESP_O = bresp_q;

  // AXI4-Lite read channel and register read selection
  logic [31:0] rd_mux, rd_q, status_w;
  logic [1:0] rresp_q;
  assign status_w = {24'h0, op, b_drv, dir_ok, tcr_q};
  assign ar_hit = S_AXI_ARADDR_I == ADDR_CTRL
    || S_AXI_ARADDR_I == ADDR_STATUS || S_AXI_ARADDR_I == ADDR_BND_LO
    || S_AXI_ARADDR_I == ADDR_BND_HI;
  assign rd_mux = (S_AXI_ARADDR_I == ADDR_CTRL) ? {31'h0, en_q} :
    (S_AXI_ARADDR_I == ADDR_STATUS) ? status_w :
    (S_AXI_ARADDR_I == ADDR_BND_LO) ? sr_q[31:0] :
    (S_AXI_ARADDR_I == ADDR_BND_HI) ? {20'h0, sr_q[CELLS-1:32]} : 32'h0;
  assign S_AXI_ARREADY_O = ~rv_q;
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rv_q <= 1'b0;
      rd_q <= '0;
      rresp_q <= RESP_OK;
    end else if (S_AXI_ARVALID_I && !rv_q) begin
      rv_q <= 1'b1;
      rd_q <= rd_mux;
      rresp_q <= ar_hit ? RESP_OK : RESP_ERR;
    end else if (rv_q && S_AXI_RREADY_I)
      rv_q <= 1'b0;
  end
  assign S_AXI_RVALID_O = rv_q;
  assign S_AXI_RDATA_O = rd_q;
  assign S_AXI_RRESP_O = rresp_q;

  // Checks on the engine behaviour
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RESET_N_I);

  a_bypass_zero: assert property (
    rise && byp_sel && tap_q.capture_dr |=> byp_q == 1'b0)
    else $error("bypass did not capture zero");
  a_toggle_out_inv: assert property (
    rise && tog_ok && !run_ok && !bnd_shift
    |=> sr_q[DATA-1:0] == ($past(sr_q[DATA-1:0]) ^ $past(out_mask)))
    else $error("toggle did not invert output cells");
  a_toggle_in_hold: assert property (
    rise && tog_ok && !run_ok && !bnd_shift
    |=> (sr_q[DATA-1:0] & ~out_mask) == ($past(sr_q[DATA-1:0]) & ~out_mask))
    else $error("toggle changed input cells");
  a_ctrl_capture: assert property (
    rise && tap_q.ctrl_scan && tap_q.capture_dr |=> $stable(tcr_q))
    else $error("control register changed in capture");
  a_run_gate_idle: assert property (
    op != OP_IDLE |-> tap_q.run_test && tap_q.run_idle && en_q)
    else $error("operation outside run-test idle");
  a_decode_full: assert property (
    run_ok && tcr_q[1:0] == LOW_PAT |-> op == OP_PATTERN)
    else $error("pattern opcode misdecoded");
  a_decode_count: assert property (
    run_ok && tcr_q == TCR_SIG_CNT |-> op == OP_SIG_CNT)
    else $error("count opcode misdecoded");
  a_ctl_cells_kept: assert property (
    rise && !bnd_shift |=> $stable(sr_q[CELLS-1:CTL_LO]))
    else $error("control cells altered by operation");
  a_dir_bypass: assert property (
    !dir_ok |-> op == OP_IDLE)
    else $error("operation ran with bad directions");
  a_sample_in: assert property (
    rise && op == OP_SAMPLE && !bnd_shift |=> in_v == $past(pins_in))
    else $error("sample did not capture pins");
  a_zero_seed: assert property (
    rise && op == OP_PATTERN && sr_q[DATA-1:0] == '0 && !bnd_shift
    |=> sr_q[DATA-1:0] == '0)
    else $error("zero seed produced a pattern");
  a_sig_freeze: assert property (
    fall && tap_s.run_test && !tap_s.toggle && tcr_q[1:0] == LOW_SIG
    && !fall_load |=> $stable(sh_q) [*2])
    else $error("shadow moved in signature mode");
  a_count_step: assert property (
    rise && op == OP_SIG_CNT && !bnd_shift
    |=> out_v == HALF'($past(out_v) + 18'h1))
    else $error("counter did not step by one");

  c_pattern: cover property (rise && op == OP_PATTERN);
  c_sig_count: cover property (rise && op == OP_SIG_CNT);
  c_toggle: cover property (rise && tog_ok);
  c_bad_dir: cover property (tap_q.run_test && tap_q.run_idle && !dir_ok);
endmodule

// [tb/brte_tap_ctl.sv]
/*
  Test-controller model: drives TCK, TDI and the TAP report.
  Assumes the engine samples all three with its own clock.
*/
`timescale 1ns/1ps
module brte_tap_ctl
  import brte_pkg::*;
(
  output logic tck_o,
  output logic tdi_o,
  output brte_pkg::brte_tap_t tap_o
);
  // TCK stands low outside frames
  initial begin
    tck_o = 1'b0;
    tdi_o = 1'b0;
    tap_o = '0;
  end

  // One 64 ns TCK period; new state and data follow the fall
  // Edges kept 1 ns off the system clock edge to avoid a sampling race
  task automatic step(input logic [7:0] nt, input logic d);
    #1;
    tck_o = 1'b1;
    #32;
    tck_o = 1'b0;
    tap_o = brte_tap_t'(nt);
    tdi_o = d;
    #31;
  endtask

  // Shift n bits, bit 0 first, then pass Update-DR
  task automatic scan(input logic [7:0] ins, input int n,
                      input logic [43:0] v);
    #3;
    for (int i = 0; i < n; i++) begin
      step(ins | 8'h02, v[i]);
    end
    step(ins | 8'h01, 1'b0);
    step(8'h00, 1'b0);
    tdi_o = ~tdi_o; // Released line shows no stale value
  endtask

  // Exactly n rising edges in Run-Test/Idle
  task automatic run(input logic [7:0] ins, input int n);
    #3;
    for (int i = 0; i < n; i++) begin
      step(ins | 8'h08, 1'b0);
    end
    step(ins, 1'b0);
  endtask
endmodule

// [tb/boundary_run_test_engine_tb.sv]
/*
  Self-checking bench of the boundary run-test engine.
  Assumes the controller model drives the link and AXI4-Lite reads
  expose the boundary cells.
*/
`timescale 1ns/1ps
module boundary_run_test_engine_tb
  import brte_pkg::*;
;
  logic clk, reset_n, tck, tdi, tdo, tdo_oe, pin_req, en;
  logic awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
  logic [3:0] awa, ara, wst;
  logic [31:0] wd, rd;
  logic [1:0] bresp, rresp;
  logic [17:0] a_i, a_o, a_oe, b_i, b_o, b_oe;
  brte_tap_t tap;
  logic [159:0] q[$];
  int seed = 32'h1a37;
  int n_mismatch = 0;
  int compares = 0;

  brte_engine brte_engine_inst (
    .CLK_I(clk), .RESET_N_I(reset_n), .TCK_I(tck), .TDI_I(tdi),
    .TAP_I(tap), .TDO_O(tdo), .TDO_OE_O(tdo_oe),
    .A_I(a_i), .A_O(a_o), .A_OE_O(a_oe),
    .B_I(b_i), .B_O(b_o), .B_OE_O(b_oe),
    .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr),
    .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(wst), .S_AXI_WVALID_I(wv),
    .S_AXI_WREADY_O(wr), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bv),
    .S_AXI_BREADY_I(br), .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv),
    .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rd), .S_AXI_RRESP_O(rresp),
    .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rr)
  );
  brte_tap_ctl brte_tap_ctl_inst (.tck_o(tck), .tdi_o(tdi), .tap_o(tap));

  // Clock, 8 ns period
  always #4 clk = ~clk;

  task automatic print_verdict;
    $display("TB: %0d compares, %0d mismatches", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Scoreboard: oldest note against each observed answer
  task automatic chk(input logic [79:0] o);
    logic [159:0] e;
    compares++;
    e = q.size() ? q.pop_front() : {80'h0, {80{1'b1}}};
    if ((o & e[79:0]) !== (e[159:80] & e[79:0])) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time,
               o & e[79:0], e[159:80] & e[79:0]);
    end
  endtask

  // Monitor of read data, write responses and pin snapshots
  always @(posedge clk) begin
    if (rv && rr) chk({46'h0, rresp, rd});
    if (bv && br) chk({78'h0, bresp});
    if (pin_req) chk({6'h0, tdo_oe, tdo, a_oe, b_oe, a_o, b_o});
  end

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
                        input logic [1:0] r);
    int k;
    q.push_back({78'h0, r, 78'h0, 2'b11});
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    for (k = 0; k < 64 && !bv; k++) begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
    end
    br <= 1'b0;
    if (k == 64) begin
      n_mismatch++;
      print_verdict();
    end
  endtask

  task automatic axi_rd(input logic [3:0] a, input logic [31:0] d,
                        input logic [31:0] m, input logic [1:0] r);
    int k;
    q.push_back({46'h0, r, d, 46'h0, 2'b11, m});
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    for (k = 0; k < 64 && !rv; k++) begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end
    rr <= 1'b0;
    if (k == 64) begin
      n_mismatch++;
      print_verdict();
    end
  endtask

  task automatic pins(input logic [79:0] d, input logic [79:0] m);
    q.push_back({d, m});
    repeat (4) @(posedge clk);
    pin_req <= 1'b1;
    @(posedge clk);
    pin_req <= 1'b0;
  endtask

  function automatic logic [35:0] lf36(input logic [35:0] s,
                                       input logic [35:0] d);
    return {s[34:0], s[T36_A] ^ s[T36_B]} ^ d;
  endfunction

  function automatic logic [17:0] lf18(input logic [17:0] s,
                                       input logic [17:0] d);
    return {s[16:0], s[T18_A] ^ s[T18_B]} ^ d;
  endfunction

  function automatic logic [2:0] op_of(input logic [2:0] c);
    if (c == 3'h3) return 3'h4;
    if (c == 3'h7) return 3'h5;
    return {1'b0, c[1:0]} + 3'h1;
  endfunction

  // Seed, select, run n edges, then check cells, status and pins
  task automatic op_check(input logic [2:0] c, input logic [7:0] t,
                          input logic [3:0] e, input int n,
                          input logic [1:0] z);
    logic [43:0] v;
    logic [35:0] f;
    logic [17:0] o, i, dat, po;
    logic bd, dk, ok;
    v = 44'({$random(seed), $random(seed)});
    v[43:40] = e;
    if (z != 2'h0) v[35:0] = {36{z[1]}};
    @(posedge clk);
    a_i <= 18'($random(seed));
    b_i <= 18'($random(seed));
    brte_tap_ctl_inst.scan(8'h10, 44, v);
    brte_tap_ctl_inst.scan(8'h20, 3, 44'(c));
    brte_tap_ctl_inst.run(t, n);
    bd = e[2];
    dk = (e[3] != e[2]) && (e[1] != e[0]) && (e[2] == e[0]);
    ok = dk && en;
    o = bd ? v[35:18] : v[17:0];
    i = bd ? v[17:0] : v[35:18];
    dat = bd ? a_i : b_i;
    po = o;
    for (int k = 0; k < n; k++) begin
      if (k == n - 1 && !(t == 8'h80 && c[1:0] == 2'h2)) po = o;
      if (t == 8'h40) o = ~o;
      else if (ok && c == 3'h3) begin
        i = lf18(i, dat);
        o = lf18(o, 18'h0);
      end else if (ok && c == 3'h7) begin
        i = lf18(i, dat);
        o = o + 18'h1;
      end else if (ok && c[1:0] == 2'h0) begin
        i = dat;
        o = ~o;
      end else if (ok) begin
        f = lf36({o, i}, c[1] ? {18'h0, dat} : 36'h0);
        o = f[35:18];
        i = f[17:0];
      end
    end
    v[35:0] = bd ? {o, i} : {i, o};
    axi_rd(ADDR_BND_LO, v[31:0], 32'hffffffff, RESP_OK);
    axi_rd(ADDR_BND_HI, {20'h0, v[43:32]}, 32'hfff, RESP_OK);
    axi_rd(ADDR_STATUS, {28'h0, dk, 3'h0}, 32'h8, RESP_OK);
    pins({2'b0, {9{v[41]}}, {9{v[43]}}, {9{v[40]}}, {9{v[42]}},
          bd ? {18'h0, po} : {po, 18'h0}},
         {2'b0, {36{1'b1}}, dk ? (bd ? 36'h3ffff : 36'hffffc0000)
                               : 36'h0});
    $display("TB: op %h instr %h enables %h done", c, t, e);
  endtask

  initial begin
    {clk, reset_n, pin_req, awv, wv, br, arv, rr} = '0;
    {awa, ara, wd, a_i, b_i} = '0;
    wst = 4'hf;
    en = 1'b1;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    axi_rd(ADDR_CTRL, 32'h1, 32'h1, RESP_OK);
    axi_rd(ADDR_STATUS, 32'h0, 32'hff, RESP_OK);
    axi_rd(4'h2, 32'h0, 32'hffffffff, RESP_ERR);
    axi_wr(4'h2, 32'h1, RESP_ERR);
    axi_wr(ADDR_STATUS, 32'hff, RESP_OK);
    axi_rd(ADDR_STATUS, 32'h0, 32'hff, RESP_OK);
    pins(80'h0, {6'h0, {74{1'b1}}});
    $display("TB: reset and register access done");
    brte_tap_ctl_inst.scan(8'h10, 44, {4'b0101, 40'h0});
    for (int c = 0; c < 8; c++) begin
      brte_tap_ctl_inst.scan(8'h20, 3, 44'(c));
      brte_tap_ctl_inst.step(8'h88, 1'b0);
      axi_rd(ADDR_STATUS, {24'h0, op_of(c[2:0]), 2'b11, c[2:0]},
             32'hff, RESP_OK);
      brte_tap_ctl_inst.step(8'h80, 1'b0);
      axi_rd(ADDR_STATUS, {24'h0, 3'h0, 2'b11, c[2:0]},
             32'hff, RESP_OK);
    end
    // TDI low in capture, so a wrong shift would clear bit 2
    brte_tap_ctl_inst.step(8'h24, 1'b0);
    brte_tap_ctl_inst.step(8'h20, 1'b0);
    brte_tap_ctl_inst.step(8'h00, 1'b0);
    axi_rd(ADDR_STATUS, 32'h7, 32'h7, RESP_OK);
    $display("TB: opcode decode done");
    op_check(3'h1, 8'h80, 4'b0101, 5, 2'h0);
    op_check(3'h5, 8'h80, 4'b0101, 4, 2'h1);
    op_check(3'h2, 8'h80, 4'b1010, 6, 2'h0);
    op_check(3'h6, 8'h80, 4'b0101, 5, 2'h0);
    op_check(3'h0, 8'h80, 4'b1010, 3, 2'h0);
    op_check(3'h4, 8'h80, 4'b0101, 2, 2'h0);
    op_check(3'h3, 8'h80, 4'b1010, 7, 2'h0);
    op_check(3'h3, 8'h80, 4'b0101, 4, 2'h0);
    op_check(3'h7, 8'h80, 4'b0101, 3, 2'h2);
    op_check(3'h7, 8'h80, 4'b1010, 4, 2'h0);
    op_check(3'h1, 8'h80, 4'b0100, 3, 2'h0);
    op_check(3'h2, 8'h80, 4'b0111, 3, 2'h0);
    op_check(3'h0, 8'h40, 4'b1010, 3, 2'h0);
    op_check(3'h1, 8'h40, 4'b0101, 4, 2'h0);
    axi_wr(ADDR_CTRL, 32'h0, RESP_OK);
    en = 1'b0;
    op_check(3'h1, 8'h80, 4'b0101, 3, 2'h0);
    axi_wr(ADDR_CTRL, 32'h1, RESP_OK);
    en = 1'b1;
    brte_tap_ctl_inst.step(8'h42, 1'b1);
    brte_tap_ctl_inst.step(8'h42, 1'b1);
    brte_tap_ctl_inst.step(8'h44, 1'b1);
    brte_tap_ctl_inst.step(8'h42, 1'b1);
    pins({6'h0, 2'b10, 72'h0}, {6'h0, 2'b11, 72'h0});
    brte_tap_ctl_inst.step(8'h42, 1'b1);
    pins({6'h0, 2'b11, 72'h0}, {6'h0, 2'b11, 72'h0});
    brte_tap_ctl_inst.step(8'h00, 1'b0);
    $display("TB: bypass path done");
    print_verdict();
  end
endmodule
